// [logic/wake_pkg.sv]
/*
  wake_pkg: constants, register map and carrier types for the idle tick
  timer and multi-pin wakeup block.
  Assumes a single 100 MHz core clock and a plain register port.
*/
package wake_pkg;

  // register map (index on the plain port)
  localparam logic [3:0] OFS_POWER_CTRL = 4'h0;
  localparam logic [3:0] OFS_WINDOW_SEL = 4'h1;
  localparam logic [3:0] OFS_INT_CTRL   = 4'h2;
  localparam logic [3:0] OFS_WAKE_EN    = 4'h3;
  localparam logic [3:0] OFS_WAKE_EDGE  = 4'h4;
  localparam logic [3:0] OFS_WAKE_PEND  = 4'h5;

  // power control field positions
  localparam int unsigned IDLE_REQ_BIT = 6;
  localparam int unsigned HALT_REQ_BIT = 7;

  // interrupt control field positions
  localparam int unsigned TICK_EN_BIT   = 0;
  localparam int unsigned TICK_PEND_BIT = 1;
  localparam int unsigned PORT_GIE_BIT  = 2;
  localparam int unsigned GLOBAL_IE_BIT = 3;

  // reset values
  localparam logic [2:0] WINDOW_SEL_RESET = 3'h0;
  localparam logic [7:0] WAKE_REG_RESET   = 8'h00;

  // timing: instruction clock is the core clock divided by ten
  localparam int unsigned INSTR_DIV    = 10;
  localparam int unsigned DIV_W        = 4;
  localparam logic [3:0]  DIV_LAST     = 4'(INSTR_DIV - 1);
  // every toggle of the tap counts, so a 4k window needs bit 12 and the
  // 64k window bit 16; the timer is one bit wider than 16 for that reason
  localparam int unsigned TIMER_W      = 17;
  localparam int unsigned TAP_LOW_BIT  = 12;
  localparam logic [2:0]  TAP_SEL_MAX  = 3'h4;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_HALT
  } power_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

endpackage : wake_pkg

// [logic/idle_wake_ctrl.sv]
/*
  idle_wake_ctrl: idle tick timer with selectable tap, power mode control
  and an 8-pin edge wakeup/interrupt unit.
  Assumes rstn is asynchronous active low, core_clk is the oscillator,
  and the cpu core reacts to cpu_run and the two interrupt requests.
*/
`timescale 1ns/1ps

// Function
// [RULE1] writing one to power control bit 6 enters idle
// [RULE2] idle stops execution only; divider and timer keep running
// [RULE3] window tap selects 4k, 8k, 16k, 32k or 64k cycles
// [RULE4] timer counts every instruction cycle, idle or not
// [RULE5] tap bit toggle sets pending, may interrupt, ends idle
// [RULE6] enabled tick interrupt is requested on wake for core servicing
// [RULE7] reset or enabled pin wake also ends idle
// [RULE8] reset clears window select, choosing the 4096 cycle tap
// [RULE9] timer has no software access, start or stop
// [RULE10] dedicated enable gates tick interrupt; pending is pollable
// [RULE11] software masks tick interrupt around tap changes
// [RULE12] software clears pending before idle, then a no-op
// [RULE13] software runs two no-ops after leaving idle
// [RULE14] wake enable bit per pin allows wake from halt or idle
// [RULE15] edge bit one means falling edge, zero rising edge
// [RULE16] software disables, changes edge, clears pending, re-enables
// [RULE17] after reset software sets edges, clears pending, then enables
// [RULE18] selected edge latches pending bit; only software clears it
// [RULE19] halt is refused while any pin is enabled and pending
// [RULE20] wake registers are read/write and reset to zero
// [RULE21] pins share one request, gated by enable, port and global flags
// [RULE22] pin wake resumes core; interrupt request only when enabled
// [RULE23] instruction clock is the core clock divided by ten
// [RULE24] pin inputs are synchronised before edge detection
module idle_wake_ctrl
  import wake_pkg::*;
#(
  parameter int unsigned PINS = 8
) (
  input  wire logic            core_clk,
  input  wire logic            rstn,
  input  wire reg_req_s        bus_req,
  output logic [7:0]           rdata,
  input  wire logic [PINS-1:0] port_pins,
  output logic                 instr_tick,
  output logic                 idle_state,
  output logic                 halt_state,
  output logic                 cpu_run,
  output logic                 idle_tick_irq,
  output logic                 port_irq
);

  // instruction clock and idle tick timer
  logic [DIV_W-1:0]   div;
  logic [DIV_W-1:0]   next_div;
  logic               next_instr_tick;
  logic [TIMER_W-1:0] idle_tick_timer;
  logic [TIMER_W-1:0] next_idle_tick_timer;
  logic               tap_q;
  logic               next_tap_q;
  logic               tap_now;
  logic               tap_event;
  logic [2:0]         tap_idx;
  logic [2:0]         window_tap_field;

  always_comb begin
    next_div        = (div == DIV_LAST) ? '0 : div + 1'b1;  // [RULE23]
    next_instr_tick = (div == DIV_LAST);                    // [RULE23]
    // free running, never loaded by software
    next_idle_tick_timer = instr_tick ? idle_tick_timer + 1'b1
                                      : idle_tick_timer;  // [RULE4] [RULE9]
    // selections above 64k clamp to the widest window
    tap_idx   = (window_tap_field > TAP_SEL_MAX) ? TAP_SEL_MAX
                                                 : window_tap_field;
    tap_now   = idle_tick_timer[TAP_LOW_BIT + tap_idx];   // [RULE3]
    // a tap change compares old bit to new one, so it may fire spuriously
    tap_event  = (tap_now != tap_q);                      // [RULE5] [RULE11]
    next_tap_q = tap_now;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div             <= '0;
      instr_tick      <= 1'b0;
      idle_tick_timer <= '0;
      tap_q           <= 1'b0;
    end else begin
      div             <= next_div;
      instr_tick      <= next_instr_tick;
      idle_tick_timer <= next_idle_tick_timer;
      tap_q           <= next_tap_q;
    end
  end

  // pin synchroniser and edge detection
  logic [PINS-1:0] sync1;
  logic [PINS-1:0] sync2;
  logic [PINS-1:0] sync3;
  logic [PINS-1:0] pin_level;
  logic [PINS-1:0] next_pin_level;
  logic [PINS-1:0] wake_set;
  logic [PINS-1:0] wake_edge_select;

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    logic agree;
    // a change counts only once the second and third stages agree
    assign agree = (sync2[i] == sync3[i]);               // [RULE24]
    assign next_pin_level[i] = agree ? sync3[i] : pin_level[i];
    assign wake_set[i] = agree && (sync3[i] != pin_level[i]) &&
                         (sync3[i] != wake_edge_select[i]);  // [RULE15]
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1     <= '0;
      sync2     <= '0;
      sync3     <= '0;
      pin_level <= '0;
    end else begin
      sync1     <= port_pins;                            // [RULE24]
      sync2     <= sync1;
      sync3     <= sync2;
      pin_level <= next_pin_level;
    end
  end

  // software registers
  logic [2:0]      next_window_tap_field;
  logic            idle_tick_int_enable;
  logic            next_idle_tick_int_enable;
  logic            idle_tick_pending;
  logic            next_idle_tick_pending;
  logic            port_int_global_enable;
  logic            next_port_int_global_enable;
  logic            global_int_enable;
  logic            next_global_int_enable;
  logic [PINS-1:0] wake_enable;
  logic [PINS-1:0] next_wake_enable;
  logic [PINS-1:0] next_wake_edge_select;
  logic [PINS-1:0] wake_pending;
  logic [PINS-1:0] next_wake_pending;
  logic [7:0]      next_rdata;
  logic            wr_at;
  logic            wake_evt;
  logic            held_pending;

  assign wr_at = bus_req.wr;

  always_comb begin
    next_window_tap_field       = window_tap_field;
    next_idle_tick_int_enable   = idle_tick_int_enable;
    next_idle_tick_pending      = idle_tick_pending;
    next_port_int_global_enable = port_int_global_enable;
    next_global_int_enable      = global_int_enable;
    next_wake_enable            = wake_enable;
    next_wake_edge_select       = wake_edge_select;
    next_wake_pending           = wake_pending;
    if (wr_at) begin
      unique case (bus_req.addr)
        OFS_WINDOW_SEL: next_window_tap_field = bus_req.wdata[2:0];
        OFS_INT_CTRL: begin
          next_idle_tick_int_enable   = bus_req.wdata[TICK_EN_BIT];
          next_idle_tick_pending      = bus_req.wdata[TICK_PEND_BIT];
          next_port_int_global_enable = bus_req.wdata[PORT_GIE_BIT];
          next_global_int_enable      = bus_req.wdata[GLOBAL_IE_BIT];
        end
        OFS_WAKE_EN:   next_wake_enable      = bus_req.wdata[PINS-1:0];
        OFS_WAKE_EDGE: next_wake_edge_select = bus_req.wdata[PINS-1:0];
        OFS_WAKE_PEND: next_wake_pending     = bus_req.wdata[PINS-1:0];
        default: ;
      endcase
    end
    // hardware set wins over a clearing write in the same cycle
    if (tap_event) begin
      next_idle_tick_pending = 1'b1;                     // [RULE5] [RULE10]
    end
    next_wake_pending = next_wake_pending | wake_set;    // [RULE18]
  end

  assign wake_evt     = |(wake_set & wake_enable);       // [RULE14]
  assign held_pending = |(wake_enable & wake_pending);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      window_tap_field       <= WINDOW_SEL_RESET;        // [RULE8]
      idle_tick_int_enable   <= 1'b0;
      idle_tick_pending      <= 1'b0;
      port_int_global_enable <= 1'b0;
      global_int_enable      <= 1'b0;
      wake_enable            <= WAKE_REG_RESET;          // [RULE20]
      wake_edge_select       <= WAKE_REG_RESET;          // [RULE20]
      wake_pending           <= WAKE_REG_RESET;          // [RULE20]
    end else begin
      window_tap_field       <= next_window_tap_field;
      idle_tick_int_enable   <= next_idle_tick_int_enable;
      idle_tick_pending      <= next_idle_tick_pending;
      port_int_global_enable <= next_port_int_global_enable;
      global_int_enable      <= next_global_int_enable;
      wake_enable            <= next_wake_enable;
      wake_edge_select       <= next_wake_edge_select;
      wake_pending           <= next_wake_pending;
    end
  end

  // power mode
  power_e mode;
  power_e next_mode;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_RUN: begin
        if (wr_at && bus_req.addr == OFS_POWER_CTRL) begin
          if (bus_req.wdata[HALT_REQ_BIT] && !held_pending && !wake_evt) begin
            next_mode = MODE_HALT;                       // [RULE19]
          end else if (bus_req.wdata[IDLE_REQ_BIT] &&
                       !bus_req.wdata[HALT_REQ_BIT]) begin
            next_mode = MODE_IDLE;                       // [RULE1]
          end
        end
      end
      MODE_IDLE: begin
        if (tap_event || wake_evt) begin
          next_mode = MODE_RUN;                          // [RULE5] [RULE7]
        end
      end
      MODE_HALT: begin
        if (wake_evt) begin
          next_mode = MODE_RUN;                          // [RULE14] [RULE22]
        end
      end
    endcase
  end

  // outputs and read data, all registered
  logic next_idle_tick_irq;
  logic next_port_irq;

  always_comb begin
    next_idle_tick_irq = idle_tick_pending && idle_tick_int_enable &&
                         global_int_enable;       // [RULE6] [RULE10]
    next_port_irq = held_pending && port_int_global_enable &&
                    global_int_enable;            // [RULE21] [RULE22]
    next_rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_POWER_CTRL: begin
          next_rdata[IDLE_REQ_BIT] = (mode == MODE_IDLE);
          next_rdata[HALT_REQ_BIT] = (mode == MODE_HALT);
        end
        OFS_WINDOW_SEL: next_rdata[2:0] = window_tap_field;
        OFS_INT_CTRL: begin
          next_rdata[TICK_EN_BIT]   = idle_tick_int_enable;
          next_rdata[TICK_PEND_BIT] = idle_tick_pending;
          next_rdata[PORT_GIE_BIT]  = port_int_global_enable;
          next_rdata[GLOBAL_IE_BIT] = global_int_enable;
        end
        OFS_WAKE_EN:   next_rdata[PINS-1:0] = wake_enable;
        OFS_WAKE_EDGE: next_rdata[PINS-1:0] = wake_edge_select;
        OFS_WAKE_PEND: next_rdata[PINS-1:0] = wake_pending;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode          <= MODE_RUN;
      idle_state    <= 1'b0;
      halt_state    <= 1'b0;
      cpu_run       <= 1'b1;
      idle_tick_irq <= 1'b0;
      port_irq      <= 1'b0;
      rdata         <= 8'h00;
    end else begin
      mode          <= next_mode;
      idle_state    <= (next_mode == MODE_IDLE);
      halt_state    <= (next_mode == MODE_HALT);
      cpu_run       <= (next_mode == MODE_RUN);          // [RULE2]
      idle_tick_irq <= next_idle_tick_irq;
      port_irq      <= next_port_irq;
      rdata         <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_idle_req;
    wr_at && bus_req.addr == OFS_POWER_CTRL &&
    bus_req.wdata[IDLE_REQ_BIT] && !bus_req.wdata[HALT_REQ_BIT] &&
    mode == MODE_RUN;
  endsequence

  sequence s_idle_wake;
    mode == MODE_IDLE && (tap_event || wake_evt);
  endsequence

  property p_idle_enter;
    s_idle_req |=> idle_state && !cpu_run;
  endproperty
  a_idle_enter: assert property (p_idle_enter)  // [RULE1]
    else $error("idle request not honoured");

  property p_idle_exit;
    s_idle_wake |=> !idle_state ##0 cpu_run;
  endproperty
  a_idle_exit: assert property (p_idle_exit)  // [RULE7]
    else $error("idle not left on wake event");

  property p_div_ten;
    instr_tick |=> !instr_tick ##9 instr_tick;
  endproperty
  a_div_ten: assert property (p_div_ten)  // [RULE23]
    else $error("instruction tick not every ten cycles");

  property p_timer_count;
    instr_tick |=> idle_tick_timer == $past(idle_tick_timer) + 1'b1;
  endproperty
  a_timer_count: assert property (p_timer_count)  // [RULE4]
    else $error("idle tick timer missed a count");

  property p_tick_pending;
    tap_event |=> idle_tick_pending ##1 (idle_tick_irq ==
      $past(idle_tick_int_enable && global_int_enable));
  endproperty
  a_tick_pending: assert property (p_tick_pending)  // [RULE5]
    else $error("tap toggle did not set pending");

  property p_halt_refused;
    wr_at && bus_req.addr == OFS_POWER_CTRL &&
    bus_req.wdata[HALT_REQ_BIT] && held_pending |=> !halt_state;
  endproperty
  a_halt_refused: assert property (p_halt_refused)  // [RULE19]
    else $error("halt entered with enabled pending wake");

  property p_pin_pending;
    wake_set[0] |=> wake_pending[0];
  endproperty
  a_pin_pending: assert property (p_pin_pending)  // [RULE18]
    else $error("pin edge did not latch pending");

  property p_pending_sticky;
    (|(~wake_pending & $past(wake_pending))) |->
      $past(wr_at && bus_req.addr == OFS_WAKE_PEND);
  endproperty
  a_pending_sticky: assert property (p_pending_sticky)  // [RULE18]
    else $error("wake pending cleared without a write");

  property p_port_irq;
    ##1 port_irq == $past(held_pending && port_int_global_enable &&
                          global_int_enable);
  endproperty
  a_port_irq: assert property (p_port_irq)  // [RULE21]
    else $error("port interrupt gating wrong");

endmodule : idle_wake_ctrl

// [bench/pin_model.sv]
/*
  pin_model: the external port pins seen by the wakeup unit.
  Assumes the bench holds each commanded level for at least three cycles.
*/
`timescale 1ns/1ps
module pin_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] pin_cmd,
  output logic [7:0]      port_pins
);
  // pins change once per clock; a real pin is asynchronous, so the
  // commanded level is held long enough for the three-flop synchroniser
  always_ff @(posedge core_clk) begin
    port_pins <= pin_cmd;
  end
endmodule : pin_model

// [bench/idle_wake_ctrl_bench.sv]
/*
  idle_wake_ctrl_bench: register, pin wakeup, halt, idle and tick tests.
  Assumes the register map of wake_pkg and the pin_model partner.
*/
`timescale 1ns/1ps
module idle_wake_ctrl_bench;
  import wake_pkg::*;
  logic       core_clk;
  logic       rstn;
  reg_req_s   bus_req;
  logic [7:0] rdata;
  logic [7:0] pin_cmd;
  logic [7:0] port_pins;
  logic       instr_tick;
  logic       idle_state;
  logic       halt_state;
  logic       cpu_run;
  logic       idle_tick_irq;
  logic       port_irq;
  int         n_mismatch;
  int         tests_run;
  int         cycles;
  int         w_cyc;
  int         w_tck;
  logic [7:0] v;

  idle_wake_ctrl i_dut (
    .core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
    .port_pins(port_pins), .instr_tick(instr_tick),
    .idle_state(idle_state), .halt_state(halt_state), .cpu_run(cpu_run),
    .idle_tick_irq(idle_tick_irq), .port_irq(port_irq)
  );
  pin_model i_pins (
    .core_clk(core_clk), .pin_cmd(pin_cmd), .port_pins(port_pins)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  // two full 4k windows of ten-cycle ticks need about 82k cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t run did not finish", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask : rd_chk

  // counts cycles and instruction ticks until idle ends or max runs out
  task automatic wait_wake(input int max, output int c, output int t);
    c = 0;
    t = 0;
    while (idle_state === 1'b1 && c < max) begin
      @(posedge core_clk);
      #1;
      c = c + 1;
      if (instr_tick === 1'b1) t = t + 1;
    end
  endtask : wait_wake

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    cycles = 0;
    rstn = 1'b0;
    pin_cmd = 8'h00;
    bus_req = '{addr: 4'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    rd_chk(OFS_WINDOW_SEL, 8'h00);
    rd_chk(OFS_WAKE_EN, 8'h00);
    rd_chk(OFS_WAKE_EDGE, 8'h00);
    rd_chk(OFS_WAKE_PEND, 8'h00);
    rd_chk(4'h7, 8'h00);
    wr_reg(OFS_WAKE_EDGE, 8'hA5);
    rd_chk(OFS_WAKE_EDGE, 8'hA5);
    wr_reg(OFS_WAKE_EN, 8'h5A);
    rd_chk(OFS_WAKE_EN, 8'h5A);
    wr_reg(OFS_WAKE_EN, 8'h00);
    // tick interrupt is still masked while the tap is changed
    for (int i = 0; i < 5; i++) begin
      wr_reg(OFS_WINDOW_SEL, 8'(i));
      rd_chk(OFS_WINDOW_SEL, 8'(i));
    end
    wr_reg(OFS_WINDOW_SEL, 8'h00);
    // spacing of instruction ticks
    w_cyc = 0;
    while (instr_tick !== 1'b1 && w_cyc < 20) begin
      wait_cyc(1);
      w_cyc = w_cyc + 1;
    end
    w_cyc = 0;
    wait_cyc(1);
    while (instr_tick !== 1'b1 && w_cyc < 20) begin
      wait_cyc(1);
      w_cyc = w_cyc + 1;
    end
    chk(8'(w_cyc + 1), 8'(INSTR_DIV));
    // edges first, pending cleared, then enable
    wr_reg(OFS_WAKE_EDGE, 8'h02);
    wr_reg(OFS_WAKE_PEND, 8'h00);
    wr_reg(OFS_WAKE_EN, 8'h03);
    pin_cmd <= 8'h01;
    wait_cyc(10);
    rd_chk(OFS_WAKE_PEND, 8'h01);
    pin_cmd <= 8'h03;
    wait_cyc(10);
    rd_chk(OFS_WAKE_PEND, 8'h01);
    pin_cmd <= 8'h01;
    wait_cyc(10);
    rd_chk(OFS_WAKE_PEND, 8'h03);
    // pin 1 moves back to rising edge without a false wake
    wr_reg(OFS_WAKE_EN, 8'h01);
    wr_reg(OFS_WAKE_EDGE, 8'h00);
    wr_reg(OFS_WAKE_PEND, 8'h00);
    wr_reg(OFS_WAKE_EN, 8'h03);
    wait_cyc(10);
    rd_chk(OFS_WAKE_PEND, 8'h00);
    pin_cmd <= 8'h03;
    wait_cyc(10);
    rd_chk(OFS_WAKE_PEND, 8'h02);
    wr_reg(OFS_WAKE_PEND, 8'h00);
    pin_cmd <= 8'h00;
    wait_cyc(10);
    pin_cmd <= 8'h01;
    wait_cyc(10);
    rd_chk(OFS_WAKE_PEND, 8'h01);
    wr_reg(OFS_INT_CTRL, 8'h0C);
    wait_cyc(2);
    chk(8'(port_irq), 8'h01);
    wr_reg(OFS_INT_CTRL, 8'h04);
    wait_cyc(2);
    chk(8'(port_irq), 8'h00);
    wr_reg(OFS_POWER_CTRL, 8'h80);
    wait_cyc(2);
    chk(8'({halt_state, cpu_run}), 8'h01);
    wr_reg(OFS_WAKE_PEND, 8'h00);
    wr_reg(OFS_POWER_CTRL, 8'h80);
    wait_cyc(2);
    chk(8'({halt_state, cpu_run}), 8'h02);
    pin_cmd <= 8'h00;
    wait_cyc(10);
    chk(8'(halt_state), 8'h01);
    pin_cmd <= 8'h01;
    wait_cyc(10);
    chk(8'({halt_state, cpu_run}), 8'h01);
    wr_reg(OFS_WAKE_PEND, 8'h00);
    wr_reg(OFS_POWER_CTRL, 8'h40);
    wait_cyc(2);
    chk(8'({idle_state, cpu_run}), 8'h02);
    pin_cmd <= 8'h00;
    wait_cyc(10);
    pin_cmd <= 8'h01;
    wait_cyc(10);
    chk(8'({idle_state, cpu_run}), 8'h01);
    chk(8'(idle_tick_irq), 8'h00);
    wr_reg(OFS_WAKE_EN, 8'h00);
    wr_reg(OFS_WAKE_PEND, 8'h00);
    // tick pending cleared by writing bit1 low before idle entry
    wr_reg(OFS_INT_CTRL, 8'h09);
    wr_reg(OFS_POWER_CTRL, 8'h40);
    wait_cyc(1);
    wait_wake(42000, w_cyc, w_tck);
    chk(8'(idle_state), 8'h00);
    // the request is registered one cycle after pending; the two
    // cycles also stand for the resynchronising no-ops
    wait_cyc(2);
    chk(8'(idle_tick_irq), 8'h01);
    rd_reg(OFS_INT_CTRL, v);
    chk(v & 8'h02, 8'h02);
    wr_reg(OFS_INT_CTRL, 8'h09);
    wr_reg(OFS_POWER_CTRL, 8'h40);
    wait_cyc(1);
    wait_wake(42000, w_cyc, w_tck);
    // window 0 is 4096 ticks of ten cycles, less the entry overhead
    chk(8'(w_cyc > 40880 && w_cyc <= 40960), 8'h01);
    chk(8'(w_tck > 4086 && w_tck <= 4096), 8'h01);
    wr_reg(OFS_INT_CTRL, 8'h08);
    wr_reg(OFS_WINDOW_SEL, 8'h02);
    wr_reg(OFS_INT_CTRL, 8'h08);
    wr_reg(OFS_POWER_CTRL, 8'h40);
    wait_cyc(2);
    chk(8'({idle_state, cpu_run}), 8'h02);
    @(posedge core_clk);
    rstn <= 1'b0;
    wait_cyc(2);
    chk(8'({idle_state, cpu_run}), 8'h01);
    @(posedge core_clk);
    rstn <= 1'b1;
    rd_chk(OFS_WINDOW_SEL, 8'h00);
    end_sim();
  end
endmodule : idle_wake_ctrl_bench
